/* File: rtl/asr_status_readback.v */
// four-axis status read-back registers: interrupt factors, input levels, data read-back
`timescale 1ns/1ps
`include "asr_regs.vh"

// Summary of operation
// - each axis keeps its own interrupt factor register and reads return the selected axis copy.
// - an interrupt factor event sets its own bit in that axis register only when its WR1 enable bit is set.
// - any set enabled factor drives interrupt_request_n low.
// - on a 16-bit bus reading the interrupt factor register of an axis clears its set bits.
// - once the set bits of every axis are cleared by reads the interrupt request returns high.
// - on an 8-bit bus reading the low byte clears only the low byte bits.
// - input level bits read 0 for a low input and 1 for a high input.
// - a data-read command copies the chosen internal value into both read-back words.
// - read-back value bits 15 to 0 land in the low read-back word.
// - read-back value bits 31 to 16 land in the high read-back word.
// - read-back values are plain binary, negatives in 32-bit two's complement.
module asr_status_readback (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [39:0] factor_events,
  input  wire [7:0]  axis_in_x,
  input  wire [7:0]  axis_in_y,
  input  wire [7:0]  axis_in_z,
  input  wire [7:0]  axis_in_u,
  input  wire [31:0] value_logical,
  input  wire [31:0] value_real,
  input  wire [31:0] value_speed,
  input  wire [31:0] value_aux,
  output wire [3:0]  axis_select,
  output wire        interrupt_request_n
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one-hot axis mask to the index of its lowest set bit
  function [1:0] axis_index;
    input [3:0] mask;
    begin
      if (mask[0]) begin
        axis_index = 2'd0;
      end else if (mask[1]) begin
        axis_index = 2'd1;
      end else if (mask[2]) begin
        axis_index = 2'd2;
      end else begin
        axis_index = 2'd3;
      end
    end
  endfunction

  // strobe qualified by one register offset
  function addr_hit;
    input       strobe;
    input [3:0] addr;
    input [3:0] offset;
    begin
      addr_hit = strobe && (addr == offset);
    end
  endfunction

  // per-axis clear mask: only the axis being read out loses its flags
  function [`ASR_IF_W-1:0] axis_clear;
    input [1:0]           axis;
    input [1:0]           sel_idx;
    input [`ASR_IF_W-1:0] mask;
    begin
      if (axis == sel_idx) begin
        axis_clear = mask;
      end else begin
        axis_clear = {`ASR_IF_W{1'b0}};
      end
    end
  endfunction

  // ****************************************************************
  // pin synchronisers for the external input levels
  // ****************************************************************
  reg  [31:0] in_meta_q;
  reg  [31:0] in_sync_q;
  wire [31:0] in_raw;

  assign in_raw = {axis_in_u, axis_in_z, axis_in_y, axis_in_x};

  // only the second stage is read; the first may still be settling
  always @(posedge clock) begin
    if (sys_rst) begin
      in_meta_q <= `ASR_RST_SYNC;
      in_sync_q <= `ASR_RST_SYNC;
    end else if (clk_en) begin
      in_meta_q <= in_raw;
      in_sync_q <= in_meta_q;
    end
  end

  // ****************************************************************
  // register port decode
  // ****************************************************************
  // every write and clearing read offset is matched here once, so the decodes cannot drift apart
  // a write and a read never share a cycle, so the decodes are independent
  wire wr_cmd;
  wire wr_wr1;
  wire wr_buscfg;
  wire rd_ifs;
  wire rd_ifs_lo;
  wire rd_ifs_hi;

  assign wr_cmd    = addr_hit(reg_wr, reg_addr, `ASR_OFF_CMD);
  assign wr_wr1    = addr_hit(reg_wr, reg_addr, `ASR_OFF_WR1);
  assign wr_buscfg = addr_hit(reg_wr, reg_addr, `ASR_OFF_BUSCFG);
  assign rd_ifs    = addr_hit(reg_rd, reg_addr, `ASR_OFF_IFS);
  assign rd_ifs_lo = addr_hit(reg_rd, reg_addr, `ASR_OFF_IFS_LO);
  assign rd_ifs_hi = addr_hit(reg_rd, reg_addr, `ASR_OFF_IFS_HI);

  // ****************************************************************
  // command and configuration registers
  // ****************************************************************
  reg  [3:0]  axis_q;
  reg  [15:0] wr1_q [0:3];
  reg         bus8_q;
  reg  [31:0] rb_q;
  reg  [31:0] rb_d;
  reg         rb_load;
  wire [3:0]  cmd_op;
  wire [3:0]  cmd_ax;
  wire        cmd_wr;
  wire [1:0]  ax_idx;
  integer     i;
  integer     k;

  assign cmd_op      = reg_wdata[`ASR_CMD_OP_MSB:`ASR_CMD_OP_LSB];
  assign cmd_ax      = reg_wdata[`ASR_CMD_AX_MSB:`ASR_CMD_AX_LSB];
  assign cmd_wr      = wr_cmd;
  assign ax_idx      = axis_index(axis_q);
  assign axis_select = axis_q;

  // ****************************************************************
  // data read-back capture
  // ****************************************************************
  // chooses the value captured by a data-read command
  always @* begin
    rb_d    = 32'h00000000;
    rb_load = 1'b0;
    if (cmd_wr) begin
      case (cmd_op)
        `ASR_OP_READ_LP: begin
          rb_d    = value_logical;
          rb_load = 1'b1;
        end
        `ASR_OP_READ_RP: begin
          rb_d    = value_real;
          rb_load = 1'b1;
        end
        `ASR_OP_READ_CV: begin
          rb_d    = value_speed;
          rb_load = 1'b1;
        end
        `ASR_OP_READ_AUX: begin
          rb_d    = value_aux;
          rb_load = 1'b1;
        end
        default: begin
          rb_d    = 32'h00000000;
          rb_load = 1'b0;
        end
      endcase
    end
  end

  // the capture holds until the next data-read command, so both words pair up
  always @(posedge clock) begin
    if (sys_rst) begin
      rb_q <= `ASR_RST_RB;
    end else if (clk_en) begin
      if (rb_load) begin
        rb_q <= rb_d;
      end
    end
  end

  // ****************************************************************
  // selection and configuration updates
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      axis_q <= `ASR_RST_AXIS;
    end else if (clk_en) begin
      // an empty axis field keeps the earlier choice
      if (wr_cmd && (cmd_op == `ASR_OP_AXIS_SEL) && (cmd_ax != 4'h0)) begin
        axis_q <= cmd_ax;
      end
    end
  end

  // byte mode changes which offsets clear; switch it with no read in flight
  always @(posedge clock) begin
    if (sys_rst) begin
      bus8_q <= `ASR_RST_BUSCFG;
    end else if (clk_en) begin
      if (wr_buscfg) begin
        bus8_q <= reg_wdata[0];
      end
    end
  end

  // writes reach every axis named in the selection
  always @(posedge clock) begin
    if (sys_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        wr1_q[i] <= `ASR_RST_WR1;
      end
    end else if (clk_en) begin
      if (wr_wr1) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (axis_q[i]) begin
            wr1_q[i] <= reg_wdata;
          end
        end
      end
    end
  end

  // ****************************************************************
  // per-axis interrupt factor flags
  // ****************************************************************
  wire [`ASR_IF_W-1:0] flags   [0:3];
  wire [3:0]           pending;
  reg  [`ASR_IF_W-1:0] clr     [0:3];
  wire                 rd_full;
  wire                 rd_lo;
  wire                 rd_hi;
  wire [`ASR_IF_W-1:0] clr_sel;

  // word read clears all bits; byte reads clear only their byte
  // a word read in byte mode only looks; the byte offsets do the clearing
  assign rd_full = rd_ifs && !bus8_q;
  assign rd_lo   = rd_ifs_lo && bus8_q;
  assign rd_hi   = rd_ifs_hi && bus8_q;
  assign clr_sel = {{(`ASR_IF_W-8){rd_full | rd_hi}}, {8{rd_full | rd_lo}}};

  // unread axes keep their flags and so keep the request asserted
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      clr[k] = axis_clear(k[1:0], ax_idx, clr_sel);
    end
  end

  // one flag bank per axis; banks share nothing but the clear decode
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_axis
      asr_axis_flags u_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .events  (factor_events[g*`ASR_IF_W +: `ASR_IF_W]),
        .enable  (wr1_q[g][`ASR_IF_W-1:0]),
        .clear   (clr[g]),
        .flags   (flags[g]),
        .pending (pending[g])
      );
    end
  endgenerate

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  // one shared line: the host finds the axis by reading each status copy
  // low while any axis has a flag set, high again once all are read out
  assign interrupt_request_n = ~(|pending);

  // ****************************************************************
  // read data path
  // ****************************************************************
  wire [15:0] ifs_word;
  wire [15:0] in_a;
  wire [15:0] in_b;
  reg  [15:0] rdata_d;

  assign ifs_word = {{(16-`ASR_IF_W){1'b0}}, flags[ax_idx]};
  assign in_a     = {in_sync_q[15:8], in_sync_q[7:0]};
  assign in_b     = {in_sync_q[31:24], in_sync_q[23:16]};

  // idle cycles and unmapped offsets read as zero, so a stale word never lingers
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ASR_OFF_CMD: begin
          rdata_d = {12'h000, axis_q};
        end
        `ASR_OFF_WR1: begin
          rdata_d = wr1_q[ax_idx];
        end
        `ASR_OFF_IFS: begin
          rdata_d = ifs_word;
        end
        `ASR_OFF_IFS_LO: begin
          rdata_d = {8'h00, ifs_word[7:0]};
        end
        `ASR_OFF_IFS_HI: begin
          rdata_d = {8'h00, ifs_word[15:8]};
        end
        `ASR_OFF_INA: begin
          rdata_d = in_a;
        end
        `ASR_OFF_INB: begin
          rdata_d = in_b;
        end
        `ASR_OFF_RBL: begin
          rdata_d = rb_q[15:0];
        end
        `ASR_OFF_RBH: begin
          rdata_d = rb_q[31:16];
        end
        `ASR_OFF_BUSCFG: begin
          rdata_d = {15'h0000, bus8_q};
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // registering the mux keeps the read data off the strobe's combinational path
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= `ASR_RST_RDATA;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

/* File: include/asr_regs.vh */
// register offsets, field positions and reset values of the axis status read-back block
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// register offsets on the plain register port (word addressed)
`define ASR_ADDR_W          4
`define ASR_OFF_CMD         4'h0
`define ASR_OFF_WR1         4'h1
`define ASR_OFF_IFS         4'h3
`define ASR_OFF_IFS_LO      4'h8
`define ASR_OFF_IFS_HI      4'h9
`define ASR_OFF_INA         4'h4
`define ASR_OFF_INB         4'h5
`define ASR_OFF_RBL         4'h6
`define ASR_OFF_RBH         4'h7
`define ASR_OFF_BUSCFG      4'hA

// command register fields
`define ASR_CMD_OP_LSB      4
`define ASR_CMD_OP_MSB      7
`define ASR_CMD_AX_LSB      0
`define ASR_CMD_AX_MSB      3
`define ASR_OP_AXIS_SEL     4'h0
`define ASR_OP_READ_LP      4'h1
`define ASR_OP_READ_RP      4'h2
`define ASR_OP_READ_CV      4'h3
`define ASR_OP_READ_AUX     4'h4

// interrupt factor bit positions
`define ASR_IF_PULSE        0
`define ASR_IF_GE_LO        1
`define ASR_IF_LT_LO        2
`define ASR_IF_LT_HI        3
`define ASR_IF_GE_HI        4
`define ASR_IF_CS_END       5
`define ASR_IF_CS_START     6
`define ASR_IF_DRV_END      7
`define ASR_IF_HOME_END     8
`define ASR_IF_SYNC         9
`define ASR_IF_W            10

// reset values
`define ASR_RST_AXIS        4'h1
`define ASR_RST_WR1         16'h0000
`define ASR_RST_BUSCFG      1'b0
`define ASR_RST_RB          32'h00000000
`define ASR_RST_RDATA       16'h0000
`define ASR_RST_SYNC        32'h00000000

`endif

/* File: rtl/asr_axis_flags.v */
// per-axis interrupt factor flags with enable gating and clear on read
`timescale 1ns/1ps
`include "asr_regs.vh"
module asr_axis_flags (
  input  wire                    clock,
  input  wire                    sys_rst,
  input  wire                    clk_en,
  input  wire [`ASR_IF_W-1:0]    events,
  input  wire [`ASR_IF_W-1:0]    enable,
  input  wire [`ASR_IF_W-1:0]    clear,
  output wire [`ASR_IF_W-1:0]    flags,
  output wire                    pending
);

  reg  [`ASR_IF_W-1:0] flag_q;
  wire [`ASR_IF_W-1:0] flag_d;

  // a new event in the clearing cycle survives the clear
  assign flag_d  = (flag_q & ~clear) | (events & enable);
  assign flags   = flag_q;
  assign pending = |flag_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      flag_q <= {`ASR_IF_W{1'b0}};
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end

endmodule

/* File: tb/asr_status_readback_sva.sv */
// checker of the axis status read-back ports
`timescale 1ns/1ps
`include "asr_regs.vh"
module asr_status_readback_chk (
  input wire        clock,
  input wire        sys_rst,
  input wire        clk_en,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire [39:0] factor_events,
  input wire [7:0]  axis_in_x,
  input wire [7:0]  axis_in_y,
  input wire [7:0]  axis_in_z,
  input wire [7:0]  axis_in_u,
  input wire [3:0]  axis_select,
  input wire        interrupt_request_n
);
  wire [3:0]  mask   = reg_wdata[3:0];
  wire        any_ev = |factor_events;
  wire [15:0] in_a   = {axis_in_y, axis_in_x};
  wire [15:0] in_b   = {axis_in_u, axis_in_z};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_sel_rst;
    $fell(sys_rst) |-> axis_select == `ASR_RST_AXIS;
  endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("axis select reset");
  // an empty axis mask must leave the selection alone
  property p_sel_wr;
    clk_en && reg_wr && reg_addr == `ASR_OFF_CMD && reg_wdata[7:4] == `ASR_OP_AXIS_SEL
      |=> axis_select == (($past(mask) == 4'h0) ? $past(axis_select) : $past(mask));
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("axis select write");
  property p_irq_fall;
    $fell(interrupt_request_n) |-> $past(any_ev);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq without event");
  property p_irq_hold;
    !interrupt_request_n && !reg_rd |=> !interrupt_request_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_irq_rise;
    $rose(interrupt_request_n) && !$past(sys_rst) |-> $past(reg_rd);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose unread");
  property p_in_a;
    (clk_en && $stable(in_a)) [*3] ##0 (reg_rd && reg_addr == `ASR_OFF_INA)
      |=> reg_rdata == $past(in_a);
  endproperty
  a_in_a: assert property (p_in_a) else $error("input level a");
  property p_in_b;
    (clk_en && $stable(in_b)) [*3] ##0 (reg_rd && reg_addr == `ASR_OFF_INB)
      |=> reg_rdata == $past(in_b);
  endproperty
  a_in_b: assert property (p_in_b) else $error("input level b");
  property p_rd_idle;
    clk_en && !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  // a low clock enable freezes every registered output
  property p_freeze;
    !clk_en |=> $stable(reg_rdata) && $stable(axis_select) && $stable(interrupt_request_n);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
bind asr_status_readback asr_status_readback_chk chk_u (.clock, .sys_rst, .clk_en,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .factor_events, .axis_in_x,
  .axis_in_y, .axis_in_z, .axis_in_u, .axis_select, .interrupt_request_n);

/* File: tb/asr_host_model.sv */
// host processor model on the plain register port
`timescale 1ns/1ps
module asr_host_model (
  input  wire        clock,
  output reg  [3:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd,
  input  wire [15:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle address is inverted after each access, and idle data after a write, so stale values never look valid
  task wr(input [3:0] a, input [15:0] w);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~w;
    end
  endtask
  task rd(input [3:0] a, output [15:0] r);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge clock);
      r = reg_rdata;
    end
  endtask
endmodule

/* File: tb/tb_asr_status_readback.sv */
// self-checking bench of the axis status read-back block
`timescale 1ns/1ps
`include "asr_regs.vh"
module tb_asr_status_readback;
  reg         clock;
  reg         sys_rst;
  reg         clk_en;
  reg  [39:0] ev;
  reg  [31:0] v [0:3];
  reg  [7:0]  p [0:3];
  wire [3:0]  reg_addr;
  wire [15:0] reg_wdata;
  wire        reg_wr;
  wire        reg_rd;
  wire [15:0] reg_rdata;
  wire [3:0]  sel;
  wire        irq_n;
  reg  [15:0] d;
  reg  [31:0] e;
  integer     seed;
  integer     n_fail;
  integer     checks;
  integer     i;
  integer     a;
  asr_host_model hst_u (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  asr_status_readback dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .factor_events(ev), .axis_in_x(p[0]), .axis_in_y(p[1]),
    .axis_in_z(p[2]), .axis_in_u(p[3]), .value_logical(v[0]), .value_real(v[1]),
    .value_speed(v[2]), .value_aux(v[3]), .axis_select(sel), .interrupt_request_n(irq_n));
  task chk(input string w, input [15:0] x, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("mismatch %s exp %h got %h", w, x, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
  end
  initial begin
    seed = 22394;
    n_fail = 0;
    checks = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    ev = 40'h0;
    for (i = 0; i < 4; i = i + 1) begin
      v[i] = $random(seed);
      p[i] = $random(seed);
    end
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock) chk("sel", `ASR_RST_AXIS, sel);
    @(posedge clock) ev <= {40{1'b1}};
    @(posedge clock) ev <= 40'h0;
    @(negedge clock) chk("irq_n", 16'h1, irq_n);
    // noise goes to higher axes whose factors are still disabled
    for (a = 0; a < 4; a = a + 1) begin
      hst_u.wr(`ASR_OFF_CMD, 16'h1 << a);
      hst_u.wr(`ASR_OFF_WR1, 16'h03FF);
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge clock) ev <= ({$random(seed), 8'h00} & ~((40'h1 << (a * 10 + 10)) - 40'h1))
          | (40'h1 << (a * 10 + i));
        @(posedge clock) ev <= 40'h0;
        @(negedge clock) chk("irq_n", 16'h0, irq_n);
        hst_u.rd(`ASR_OFF_IFS, d);
        chk("ifs", 16'h1 << i, d);
        @(negedge clock) chk("irq_n", 16'h1, irq_n);
        hst_u.rd(`ASR_OFF_IFS, d);
        chk("ifs", 16'h0, d);
      end
    end
    hst_u.wr(`ASR_OFF_BUSCFG, 16'h0001);
    @(posedge clock) ev <= 40'h101 << 30;
    @(posedge clock) ev <= 40'h0;
    hst_u.rd(`ASR_OFF_IFS, d);
    chk("ifs", 16'h0101, d);
    hst_u.rd(`ASR_OFF_IFS_LO, d);
    chk("lo", 16'h0001, d);
    hst_u.rd(`ASR_OFF_IFS_LO, d);
    chk("lo", 16'h0000, d);
    @(negedge clock) chk("irq_n", 16'h0, irq_n);
    hst_u.rd(`ASR_OFF_IFS_HI, d);
    chk("hi", 16'h0001, d);
    @(negedge clock) chk("irq_n", 16'h1, irq_n);
    hst_u.wr(`ASR_OFF_BUSCFG, 16'h0000);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clock);
      for (a = 0; a < 4; a = a + 1)
        p[a] <= (i == 0) ? 8'hA5 : $random(seed);
      repeat (3) @(posedge clock);
      hst_u.rd(`ASR_OFF_INA, d);
      chk("ina", {p[1], p[0]}, d);
      hst_u.rd(`ASR_OFF_INB, d);
      chk("inb", {p[3], p[2]}, d);
    end
    for (i = 1; i < 5; i = i + 1) begin
      @(posedge clock) v[i - 1] <= (i == 2) ? 32'hFFFFFFFE : $random(seed);
      hst_u.wr(`ASR_OFF_CMD, {8'h00, i[3:0], 4'h0});
      e = v[i - 1];
      hst_u.rd(`ASR_OFF_RBL, d);
      chk("rbl", e[15:0], d);
      hst_u.rd(`ASR_OFF_RBH, d);
      chk("rbh", e[31:16], d);
    end
    hst_u.rd(4'hF, d);
    chk("void", 16'h0000, d);
    // an empty axis field must leave axis 3 selected
    hst_u.wr(`ASR_OFF_CMD, 16'h0000);
    @(negedge clock) chk("sel", 16'h8, sel);
    hst_u.wr(`ASR_OFF_WR1, 16'h0080);
    @(posedge clock) ev <= 40'h80 << 30;
    @(posedge clock) ev <= 40'h0;
    @(negedge clock) chk("irq_n", 16'h0, irq_n);
    // mid-run reset with a request pending
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock) chk("sel", `ASR_RST_AXIS, sel);
    chk("irq_n", 16'h1, irq_n);
    hst_u.wr(`ASR_OFF_WR1, 16'h0001);
    // an enabled event while the clock enable is low must be lost
    @(posedge clock) clk_en <= 1'b0;
    ev <= 40'h1;
    @(posedge clock) clk_en <= 1'b1;
    ev <= 40'h0;
    @(negedge clock) chk("frozen", 16'h1, irq_n);
    @(posedge clock) ev <= 40'h1;
    @(posedge clock) ev <= 40'h0;
    @(negedge clock) chk("irq_n", 16'h0, irq_n);
    close_out;
  end
endmodule
